// file: design/byte_serial_crc16_unit.sv
// Byte serial CRC-16 unit behind an AXI4-Lite slave, with its byte FIFO.
// Assumes one clock, synchronous active-low reset, a master on the same clock.
`timescale 1ns/1ns

// Byte FIFO between the bus and the CRC engine
module crc_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [LW-1:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [LW-1:0] next_count;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Honest flags straight from the occupancy count
    assign in_ready_o = (count != LW'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb begin
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + LW'(1);
        end else if (pop && !push) begin
            next_count = count - LW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage needs no reset; a slot is only popped after it has been written
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

// CRC engine and register file
module byte_serial_crc16_unit
    import crc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire axil_req_type axil_i,
    output axil_rsp_type axil_o
);
    axil_rsp_type rsp;
    axil_rsp_type next_rsp;
    wr_state_type wr_state;
    wr_state_type next_wr_state;
    logic aw_held;
    logic next_aw_held;
    logic [`ADDR_W-1:0] aw_addr;
    logic [`ADDR_W-1:0] next_aw_addr;
    logic w_held;
    logic next_w_held;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic ar_held;
    logic next_ar_held;
    logic [`ADDR_W-1:0] ar_addr;
    logic [`ADDR_W-1:0] next_ar_addr;
    logic rd_ctrl;
    logic next_rd_ctrl;
    logic [15:0] running_checksum;
    logic [15:0] next_running_checksum;
    polynomial_select_sel_type polynomial_select;
    polynomial_select_sel_type next_polynomial_select;
    logic [7:0] crc_byte_input;
    logic [7:0] next_crc_byte_input;
    logic pause;
    logic next_pause;
    reg_sel_type wr_idx;
    reg_sel_type rd_idx;
    logic wr_go;
    logic rd_go;
    logic push;
    logic pop;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [3:0] fifo_level;
    logic fifo_empty;

    // Address decode, shared by the read and write paths
    function automatic reg_sel_type decode(input logic [`ADDR_W-1:0] addr);
        case (addr)
            `OFS_INPUT: decode = reg_input;
            `OFS_LOW: decode = reg_low;
            `OFS_HIGH: decode = reg_high;
            `OFS_CTRL: decode = reg_ctrl;
            `OFS_ENGINE: decode = reg_engine;
            `OFS_STATUS: decode = reg_status;
            default: decode = reg_none;
        endcase
    endfunction

    // Whole byte folded in one pass of combinational logic
    function automatic logic [15:0] crc_step(input logic [15:0] sum_in,
        input logic [7:0] data, input polynomial_select_sel_type s);
        logic [15:0] t;
        logic [15:0] p;
        logic msb;
        p = (s == polynomial_select_crc16) ? `POLYNOMIAL_SELECT_CRC16 : `POLYNOMIAL_SELECT_CCITT;
        t = sum_in ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            msb = t[15];
            t = {t[14:0], 1'b0};
            if (msb) begin
                t = t ^ p;
            end
        end
        crc_step = t;
    endfunction

    assign axil_o = rsp;
    assign wr_idx = decode(aw_addr);
    assign rd_idx = decode(ar_addr);
    assign fifo_empty = (fifo_level == 4'h0);
    assign pop = fifo_valid && !pause;

    // Checksum and control writes wait for the FIFO to drain, keeping byte order
    assign wr_go = (wr_state == wr_collect) && aw_held && w_held
        && ((wr_idx == reg_input) ? fifo_in_ready
        : (wr_idx inside {reg_low, reg_high, reg_ctrl}) ? fifo_empty : 1'b1);
    assign push = wr_go && (wr_idx == reg_input) && w_strb[0];
    // Checksum reads wait until queued bytes are folded in, unless paused
    assign rd_go = ar_held && !rsp.rvalid
        && (!(rd_idx inside {reg_low, reg_high}) || fifo_empty || pause);

    crc_byte_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) byte_queue (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(push),
        .in_data_i(w_data[7:0]),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(!pause),
        .level_o(fifo_level)
    );

    // Bus handshakes, holding registers and answers
    always_comb begin
        next_rsp = rsp;
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_ar_held = ar_held;
        next_ar_addr = ar_addr;
        next_rd_ctrl = rd_ctrl;
        if (axil_i.awvalid && rsp.awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = axil_i.awaddr;
        end
        if (axil_i.wvalid && rsp.wready) begin
            next_w_held = 1'b1;
            next_w_data = axil_i.wdata;
            next_w_strb = axil_i.wstrb;
        end
        unique case (wr_state)
            wr_collect: begin
                if (wr_go) begin
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_rsp.bvalid = 1'b1;
                    next_rsp.bresp = (wr_idx == reg_none) ? `RESP_SLVERR : `RESP_OKAY;
                    next_wr_state = wr_respond;
                end
            end
            wr_respond: begin
                if (axil_i.bready) begin
                    next_rsp.bvalid = 1'b0;
                    next_wr_state = wr_collect;
                end
            end
        endcase
        if (axil_i.arvalid && rsp.arready) begin
            next_ar_held = 1'b1;
            next_ar_addr = axil_i.araddr;
        end
        if (rsp.rvalid && axil_i.rready) begin
            next_rsp.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_ar_held = 1'b0;
            next_rd_ctrl = (rd_idx == reg_ctrl);
            next_rsp.rvalid = 1'b1;
            next_rsp.rresp = (rd_idx == reg_none) ? `RESP_SLVERR : `RESP_OKAY;
            unique case (rd_idx)
                reg_input: next_rsp.rdata = {24'h000000, crc_byte_input};
                reg_low: next_rsp.rdata = {24'h000000, running_checksum[7:0]};
                reg_high: next_rsp.rdata = {24'h000000, running_checksum[15:8]};
                reg_ctrl: next_rsp.rdata = {31'h00000000, polynomial_select};
                reg_engine: next_rsp.rdata = {31'h00000000, pause};
                reg_status: next_rsp.rdata = {24'h000000, fifo_level, 2'h0,
                    !fifo_in_ready, fifo_empty};
                reg_none: next_rsp.rdata = 32'h00000000;
                default: next_rsp.rdata = 32'h00000000;
            endcase
        end
        next_rsp.awready = !next_aw_held;
        next_rsp.wready = !next_w_held;
        next_rsp.arready = !next_ar_held && !next_rsp.rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rsp <= '0;
            wr_state <= wr_collect;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            ar_held <= 1'b0;
            ar_addr <= '0;
            rd_ctrl <= 1'b0;
        end else begin
            rsp <= next_rsp;
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            ar_held <= next_ar_held;
            ar_addr <= next_ar_addr;
            rd_ctrl <= next_rd_ctrl;
        end
    end

    // Register file and checksum; checksum and control loads never meet a pop since they need an empty FIFO
    always_comb begin
        next_running_checksum = running_checksum;
        next_polynomial_select = polynomial_select;
        next_crc_byte_input = crc_byte_input;
        next_pause = pause;
        if (pop) begin
            next_running_checksum = crc_step(running_checksum, fifo_data,
                polynomial_select);
        end
        if (wr_go && w_strb[0]) begin
            unique case (wr_idx)
                reg_input: next_crc_byte_input = w_data[7:0];
                reg_low: next_running_checksum[7:0] = w_data[7:0];
                reg_high: next_running_checksum[15:8] = w_data[7:0];
                reg_ctrl: next_polynomial_select = polynomial_select_sel_type'(w_data[`CTRL_POLYNOMIAL_SELECT_BIT]);
                reg_engine: next_pause = w_data[`ENGINE_PAUSE_BIT];
                reg_status, reg_none: begin
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            running_checksum <= `RST_SUM;
            polynomial_select <= polynomial_select_ccitt;
            crc_byte_input <= `RST_BYTE;
            pause <= 1'b0;
        end else begin
            running_checksum <= next_running_checksum;
            polynomial_select <= next_polynomial_select;
            crc_byte_input <= next_crc_byte_input;
            pause <= next_pause;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Byte accepted into an empty, running queue
    sequence byte_taken;
        push && fifo_empty && !pause;
    endsequence
    // Engine pops that very byte one cycle later
    sequence byte_popped;
        pop && (fifo_data == $past(w_data[7:0]));
    endsequence

    AST_UPDATE_ON_POP: assert property (
        pop |=> running_checksum
            == crc_step($past(running_checksum), $past(fifo_data), $past(polynomial_select)))
        else $error("checksum not folded from popped byte");

    AST_ONE_CYCLE: assert property (
        byte_taken |-> ##1 byte_popped ##1 (running_checksum
            == crc_step($past(running_checksum), $past(fifo_data), $past(polynomial_select))))
        else $error("byte not folded within one cycle of queueing");

    AST_CCITT_SELECT: assert property (
        (pop && polynomial_select == polynomial_select_ccitt && fifo_data == 8'h01
            && running_checksum == 16'h0000) |=> running_checksum == 16'h1021)
        else $error("CCITT polynomial not applied");

    AST_CRC16_SELECT: assert property (
        (pop && polynomial_select == polynomial_select_crc16 && fifo_data == 8'h01
            && running_checksum == 16'h0000) |=> running_checksum == 16'h8005)
        else $error("CRC-16 polynomial not applied");

    AST_CHAIN: assert property (
        (pop ##1 pop) |=> running_checksum == crc_step(crc_step($past(running_checksum, 2),
            $past(fifo_data, 2), $past(polynomial_select, 2)),
            $past(fifo_data), $past(polynomial_select)))
        else $error("successive bytes not chained");

    AST_RESET_ZERO: assert property (
        !$past(resetn_i) |-> running_checksum == 16'h0000
            && polynomial_select == polynomial_select_ccitt && crc_byte_input == 8'h00)
        else $error("registers not zero after reset");

    AST_CTRL_UPPER_ZERO: assert property (
        ($rose(rsp.rvalid) && rd_ctrl) |-> rsp.rdata[31:1] == 31'h00000000
            && rsp.rdata[0] == $past(polynomial_select))
        else $error("control read shows wrong bits");

    AST_LOAD_LOW: assert property (
        (wr_go && wr_idx == reg_low && w_strb[0]) |=> running_checksum[7:0]
            == $past(w_data[7:0]) && running_checksum[15:8] == $past(running_checksum[15:8]))
        else $error("checksum low byte not loaded");
endmodule

// file: design/crc_cfg.svh
// Constants of the byte serial CRC-16 unit: offsets, fields, resets, polynomials.
// Assumes inclusion once per compile unit through the package file.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH
`define ADDR_W 8
`define OFS_INPUT 8'h00
`define OFS_LOW 8'h04
`define OFS_HIGH 8'h08
`define OFS_CTRL 8'h0C
`define OFS_ENGINE 8'h10
`define OFS_STATUS 8'h14
`define CTRL_POLYNOMIAL_SELECT_BIT 0
`define ENGINE_PAUSE_BIT 0
`define STATUS_EMPTY_BIT 0
`define STATUS_FULL_BIT 1
`define STATUS_LEVEL_LSB 4
`define RST_BYTE 8'h00
`define RST_SUM 16'h0000
`define POLYNOMIAL_SELECT_CCITT 16'h1021
`define POLYNOMIAL_SELECT_CRC16 16'h8005
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: design/crc_pkg.sv
// Types shared by the CRC unit: bus carriers, register select, states.
// Assumes crc_cfg.svh sits on the include path.
`include "crc_cfg.svh"
package crc_pkg;
    typedef enum logic {polynomial_select_ccitt, polynomial_select_crc16} polynomial_select_sel_type;
    typedef enum logic [2:0] {
        reg_input, reg_low, reg_high, reg_ctrl, reg_engine, reg_status, reg_none
    } reg_sel_type;
    typedef enum logic {wr_collect, wr_respond} wr_state_type;
    // Master to slave side of the AXI4-Lite port
    typedef struct packed {
        logic awvalid;
        logic [`ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_type;
    // Slave to master side
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_type;
endpackage

// file: tb/tb.sv
// Self-checking bench for the byte serial CRC-16 unit, driven over AXI4-Lite.
// Assumes crc_pkg is compiled first and crc_cfg.svh sits on the include path.
`timescale 1ns/1ns
`include "crc_cfg.svh"

module tb
    import crc_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    axil_req_type req = '0;
    axil_rsp_type rsp;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] resp;
    logic [15:0] sum;
    // Single-byte results from a cleared checksum, bytes 00H to 07H
    logic [15:0] tab [2][8] = '{
        '{16'h0000, 16'h1021, 16'h2042, 16'h3063, 16'h4084, 16'h50A5, 16'h60C6, 16'h70E7},
        '{16'h0000, 16'h8005, 16'h800F, 16'h000A, 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
    // Running results for the bytes 78H, 56H, 34H, 12H
    logic [15:0] seq [2][4] = '{
        '{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
        '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
    logic [7:0] seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};

    byte_serial_crc16_unit DUT (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .axil_i(req),
        .axil_o(rsp)
    );

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            test_done();
        end
    end

    // Own reference, independent of the design's update logic
    function automatic logic [15:0] crc_step(input logic [15:0] s, input logic [7:0] b,
                                             input logic p);
        logic [15:0] t;
        t = s ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            t = t[15] ? ({t[14:0], 1'b0} ^ (p ? 16'h8005 : 16'h1021)) : {t[14:0], 1'b0};
        end
        return t;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One write; address and data offered together, bready held until bvalid
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        bit done;
        done = 0;
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        while (!done) begin
            @(posedge clk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                resp = rsp.bresp;
                req.bready <= 1'b0;
                done = 1;
            end
        end
        check({30'h0, resp}, {30'h0, er});
    endtask

    // One read; rready held until rvalid
    task automatic axi_read(input logic [7:0] a);
        bit done;
        done = 0;
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (!done) begin
            @(posedge clk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                rd = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, 4'hF, `RESP_OKAY);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        check(rd, exp);
    endtask

    // Checksum pair compared byte by byte
    task automatic sum_chk(input logic [15:0] exp);
        rchk(`OFS_HIGH, {24'h0, exp[15:8]});
        rchk(`OFS_LOW, {24'h0, exp[7:0]});
    endtask

    task automatic clear_sum(input logic p);
        wr(`OFS_LOW, 32'h0);
        wr(`OFS_HIGH, 32'h0);
        wr(`OFS_CTRL, {31'h0, p});
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        rchk(`OFS_INPUT, 32'h0);
        rchk(`OFS_LOW, 32'h0);
        rchk(`OFS_HIGH, 32'h0);
        rchk(`OFS_CTRL, 32'h0);
        rchk(`OFS_STATUS, 32'h1);
        // Bytes 00H to 07H from a cleared pair, both polynomials
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 8; b++) begin
                clear_sum(p[0]);
                wr(`OFS_INPUT, b);
                sum_chk(tab[p][b]);
            end
        end
        // Chained bytes, read back after each write; words 5678H, 1234H go low byte first
        for (int p = 0; p < 2; p++) begin
            clear_sum(p[0]);
            for (int i = 0; i < 4; i++) begin
                wr(`OFS_INPUT, {24'h0, seq_in[i]});
                sum_chk(seq[p][i]);
            end
        end
        rchk(`OFS_INPUT, 32'h12);
        // Upper control bits stay zero; a write without byte strobe changes nothing
        wr(`OFS_CTRL, 32'hFFFF_FFFF);
        rchk(`OFS_CTRL, 32'h1);
        wr(`OFS_CTRL, 32'h0000_00FE);
        rchk(`OFS_CTRL, 32'h0);
        axi_write(`OFS_CTRL, 32'h1, 4'h0, `RESP_OKAY);
        rchk(`OFS_CTRL, 32'h0);
        // Loaded pair seeds the next byte
        wr(`OFS_HIGH, 32'h12);
        wr(`OFS_LOW, 32'h34);
        wr(`OFS_CTRL, 32'h1);
        sum_chk(16'h1234);
        wr(`OFS_INPUT, 32'hA5);
        sum_chk(crc_step(16'h1234, 8'hA5, 1'b1));
        // Unmapped address is refused
        axi_write(8'h18, 32'h5, 4'hF, `RESP_SLVERR);
        axi_read(8'h18);
        check(rd, 32'h0);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR});
        // Engine stalled while the FIFO fills to full, then drained
        clear_sum(1'b0);
        wr(`OFS_ENGINE, 32'h1);
        rchk(`OFS_ENGINE, 32'h1);
        sum = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            wr(`OFS_INPUT, 32'h30 + i);
            sum = crc_step(sum, 8'h30 + i[7:0], 1'b0);
        end
        rchk(`OFS_STATUS, 32'h82);
        rchk(`OFS_LOW, 32'h0);
        wr(`OFS_ENGINE, 32'h0);
        sum_chk(sum);
        rchk(`OFS_STATUS, 32'h1);
        // Status ignores writes; a byte write without strobe queues nothing
        wr(`OFS_STATUS, 32'h0);
        axi_write(`OFS_INPUT, 32'h55, 4'h0, `RESP_OKAY);
        rchk(`OFS_INPUT, 32'h37);
        rchk(`OFS_STATUS, 32'h1);
        rchk(`OFS_ENGINE, 32'h0);
        sum_chk(sum);
        test_done();
    end
endmodule
